// [hdl/gpl_defines.svh]
// gpl_defines.svh: offsets, field positions, reset values and timing counts of the pin block
// assumes a 20 MHz device clock; included by bare name
`ifndef GPL_DEFINES_SVH
`define GPL_DEFINES_SVH
`define GPL_OFF_PIN_CONFIG 8'h88
`define GPL_OFF_IRQ_STATUS 8'h8C
`define GPL_OFF_IRQ_ENABLE 8'h90
`define GPL_LED_LSB 28
`define GPL_POL_LSB 24
`define GPL_ROMF_LSB 20
`define GPL_DRIVE_LSB 16
`define GPL_DIR_LSB 8
`define GPL_OOV_LSB 3
`define GPL_VAL_LSB 0
`define GPL_CFG_WMASK 32'h7777_071F
`define GPL_CFG_RESET 32'h0000_0000
`define GPL_CLK_NS 50
`define GPL_MIN_PULSE_NS 40
`define GPL_FILT_CYCLES ((`GPL_MIN_PULSE_NS + `GPL_CLK_NS - 1) / `GPL_CLK_NS)
`endif

// [hdl/gpl_if.sv]
// gpl_if: filtered pin levels from the input filter to the register block
// assumes one clock shared by both ends
`timescale 1ns/1ps
interface gpl_if;
	logic [2:0] level;
	logic [2:0] irq_hit;
	logic [2:0] polarity;
	modport filt (output level, output irq_hit, input polarity);
	modport core (input level, input irq_hit, output polarity);
endinterface : gpl_if

// [hdl/gpl_pin_config.sv]
// gpl_pin_config: pin configuration register, pin muxing and pin interrupts
// assumes a plain register port on clk_i; pins asynchronous; board resolves open-drain
//
// Local design decision: the strobed register port.
`timescale 1ns/1ps
`include "gpl_defines.svh"
// Overview of operation
// - a set led select bit gives shared pin n to the led, a clear one makes it a general pin.
// - a pin's polarity bit picks whether a high or a low level sets its interrupt status.
// - a pin interrupt reaches the host only when its enable bit is set.
// - a level must last longer than 40 ns to count as an interrupt.
// - the rom pin function field chooses what the rom data and clock pins carry.
// - a set drive-type bit makes a pin push-pull, a clear one open-drain.
// - a set direction bit makes a pin an output, a clear one an input.
// - bits 3 and 4 drive the two output-only pins when those are selected.
// - an output pin drives its data bit, and reading the data bits returns the pin levels.
module gpl_pin_config import gpl_pkg::*; #(
	parameter int FILT_CYCLES = `GPL_FILT_CYCLES
) (
	input wire logic clk_i,
	input wire logic reset_i,
	input wire logic [7:0] addr_i,
	input wire logic [31:0] wdata_i,
	input wire logic wr_i,
	input wire logic rd_i,
	output logic [31:0] rdata_o,
	output logic irq_o,
	input wire logic [2:0] pin_i,
	output logic [2:0] pin_o,
	output logic [2:0] pin_oe_o,
	input wire logic [2:0] led_i,
	input wire logic rom_data_i,
	output logic rom_data_o,
	output logic rom_data_oe_o,
	input wire logic rom_clock_i,
	input wire logic tx_en_i,
	input wire logic tx_clk_i,
	input wire logic rx_dv_i,
	input wire logic rx_clk_i,
	output logic rom_data_pin_o,
	output logic rom_data_pin_oe_o,
	output logic rom_clock_pin_o
);
	typedef struct packed {
		logic [31:0] cfg;
		logic [2:0] status;
		logic [2:0] enable;
		logic [31:0] rdata;
		logic [2:0] pin_out;
		logic [2:0] pin_oe;
		logic data_pin;
		logic data_oe;
		logic clock_pin;
	} gpl_core_type;
	gpl_core_type cur, next_cur;
	gpl_if link_p ();
	logic [2:0] led_select;
	logic [2:0] pin_irq_polarity;
	gpl_romf_type rom_pin_function;
	logic [2:0] pin_drive_type;
	logic [2:0] pin_direction;
	logic [1:0] out_only_value;
	logic [2:0] pin_value;

	// input filter with its synchroniser
	gpl_pin_filter #(.FILT_CYCLES(FILT_CYCLES)) u_filter (
		.clk_i(clk_i),
		.reset_i(reset_i),
		.pin_i(pin_i),
		.port_p(link_p.filt)
	);

	// field views of the configuration word
	assign led_select = cur.cfg[`GPL_LED_LSB +: 3];
	assign pin_irq_polarity = cur.cfg[`GPL_POL_LSB +: 3];
	assign rom_pin_function = gpl_romf_type'(cur.cfg[`GPL_ROMF_LSB +: 3]);
	assign pin_drive_type = cur.cfg[`GPL_DRIVE_LSB +: 3];
	assign pin_direction = cur.cfg[`GPL_DIR_LSB +: 3];
	assign out_only_value = cur.cfg[`GPL_OOV_LSB +: 2];
	assign pin_value = cur.cfg[`GPL_VAL_LSB +: 3];
	assign link_p.polarity = pin_irq_polarity;

	// one pin's drive: led wins, else push-pull or open-drain when an output
	function automatic logic [1:0] pin_drive(input logic led_sel, input logic led, input logic dir,
		input logic push, input logic val);
		logic [1:0] r;
		r = 2'b00;
		if (led_sel)
			r = {led, 1'b1};
		else if (dir && push)
			r = {val, 1'b1};
		else if (dir)
			r = {1'b0, !val};
		return r;
	endfunction : pin_drive

	// register access, status capture and pin muxing
	always_comb begin
		logic [1:0] d;
		logic [2:0] ev;
		d = 2'b00;
		ev = link_p.irq_hit & ~led_select;
		next_cur = cur;
		if (wr_i && addr_i == `GPL_OFF_PIN_CONFIG)
			next_cur.cfg = wdata_i & `GPL_CFG_WMASK;
		if (wr_i && addr_i == `GPL_OFF_IRQ_ENABLE)
			next_cur.enable = wdata_i[2:0];
		next_cur.rdata = 32'h0000_0000;
		if (rd_i) begin
			unique case (addr_i)
				`GPL_OFF_PIN_CONFIG: next_cur.rdata = {cur.cfg[31:3], link_p.level};
				`GPL_OFF_IRQ_STATUS: next_cur.rdata = {29'h0000_0000, cur.status};
				`GPL_OFF_IRQ_ENABLE: next_cur.rdata = {29'h0000_0000, cur.enable};
				default: next_cur.rdata = 32'h0000_0000;
			endcase
		end
		// a status read clears; a level still held sets again, set winning
		if (rd_i && addr_i == `GPL_OFF_IRQ_STATUS)
			next_cur.status = 3'h0;
		next_cur.status = next_cur.status | ev;
		for (int i = 0; i < 3; i++) begin
			d = pin_drive(led_select[i], led_i[i], pin_direction[i], pin_drive_type[i], pin_value[i]);
			next_cur.pin_out[i] = d[1];
			next_cur.pin_oe[i] = d[0];
		end
		next_cur.data_pin = 1'b0;
		next_cur.data_oe = 1'b0;
		next_cur.clock_pin = 1'b0;
		unique case (rom_pin_function)
			GPL_ROMF_ROM: begin
				next_cur.data_pin = rom_data_i;
				next_cur.data_oe = rom_data_oe_o;
				next_cur.clock_pin = rom_clock_i;
			end
			GPL_ROMF_OO_BOTH: begin
				next_cur.data_pin = out_only_value[0];
				next_cur.data_oe = 1'b1;
				next_cur.clock_pin = out_only_value[1];
			end
			GPL_ROMF_OOA_RXDV: begin
				next_cur.data_pin = out_only_value[0];
				next_cur.data_oe = 1'b1;
				next_cur.clock_pin = rx_dv_i;
			end
			GPL_ROMF_TXEN_OOB: begin
				next_cur.data_pin = tx_en_i;
				next_cur.data_oe = 1'b1;
				next_cur.clock_pin = out_only_value[1];
			end
			GPL_ROMF_TXEN_RXDV: begin
				next_cur.data_pin = tx_en_i;
				next_cur.data_oe = 1'b1;
				next_cur.clock_pin = rx_dv_i;
			end
			GPL_ROMF_CLKS: begin
				next_cur.data_pin = tx_clk_i;
				next_cur.data_oe = 1'b1;
				next_cur.clock_pin = rx_clk_i;
			end
			// reserved codes 2 and 4 pass the write mask; park the pins quietly
			default: begin
				next_cur.data_pin = 1'b0;
				next_cur.data_oe = 1'b0;
				next_cur.clock_pin = 1'b0;
			end
		endcase
	end

	always_ff @(posedge clk_i) begin
		if (reset_i)
			cur <= '0;
		else
			cur <= next_cur;
	end

	// rom data pin read path and outputs; the rom engine sees its own pin level
	assign rom_data_o = rom_data_pin_o;
	assign rom_data_oe_o = 1'b0;
	assign rdata_o = cur.rdata;
	assign irq_o = |(cur.status & cur.enable);
	assign pin_o = cur.pin_out;
	assign pin_oe_o = cur.pin_oe;
	assign rom_data_pin_o = cur.data_pin;
	assign rom_data_pin_oe_o = cur.data_oe;
	assign rom_clock_pin_o = cur.clock_pin;

	// irq can only rise after an enabled pin level or a write of the enable bits
	property p_irq_gate;
		@(posedge clk_i) disable iff (reset_i) $rose(irq_o)
			|-> $past((|(link_p.irq_hit & ~led_select & cur.enable)) || (wr_i && addr_i == `GPL_OFF_IRQ_ENABLE));
	endproperty
	a_irq_gate: assert property (p_irq_gate) else $error("irq without enabled status");
	property p_irq_masked;
		@(posedge clk_i) disable iff (reset_i)
			(rd_i && addr_i == `GPL_OFF_IRQ_ENABLE) ##1 (rdata_o[2:0] == 3'h0) |-> !irq_o;
	endproperty
	a_irq_masked: assert property (p_irq_masked) else $error("irq while all masked");
	property p_led_route;
		@(posedge clk_i) disable iff (reset_i) led_select[0] |=> (pin_oe_o[0] && pin_o[0] == $past(led_i[0]));
	endproperty
	a_led_route: assert property (p_led_route) else $error("led not routed");
	property p_input_dir;
		@(posedge clk_i) disable iff (reset_i) (!led_select[1] && !pin_direction[1]) |=> !pin_oe_o[1];
	endproperty
	a_input_dir: assert property (p_input_dir) else $error("input pin driven");
	property p_open_drain;
		@(posedge clk_i) disable iff (reset_i)
			(!led_select[2] && pin_direction[2] && !pin_drive_type[2] && pin_value[2]) |=> !pin_oe_o[2];
	endproperty
	a_open_drain: assert property (p_open_drain) else $error("open drain drove high");
	property p_push_pull;
		@(posedge clk_i) disable iff (reset_i)
			(!led_select[0] && pin_direction[0] && pin_drive_type[0]) |=> (pin_oe_o[0] && pin_o[0] == $past(pin_value[0]));
	endproperty
	a_push_pull: assert property (p_push_pull) else $error("push pull value wrong");
	property p_oo_pins;
		@(posedge clk_i) disable iff (reset_i)
			(rom_pin_function == GPL_ROMF_OO_BOTH) |=> (rom_data_pin_o == $past(out_only_value[0])
			&& rom_clock_pin_o == $past(out_only_value[1]));
	endproperty
	a_oo_pins: assert property (p_oo_pins) else $error("output-only pins wrong");
	property p_rxdv;
		@(posedge clk_i) disable iff (reset_i) (rom_pin_function == GPL_ROMF_TXEN_RXDV)
			|=> (rom_clock_pin_o == $past(rx_dv_i) && rom_data_pin_o == $past(tx_en_i));
	endproperty
	a_rxdv: assert property (p_rxdv) else $error("mii mux wrong");
	property p_rsvd;
		@(posedge clk_i) disable iff (reset_i) (rd_i && addr_i == `GPL_OFF_PIN_CONFIG) |=> (rdata_o[31] == 1'b0
			&& rdata_o[27] == 1'b0 && rdata_o[7:5] == 3'h0);
	endproperty
	a_rsvd: assert property (p_rsvd) else $error("reserved bit nonzero");
	property p_hit_sets;
		@(posedge clk_i) disable iff (reset_i) (link_p.irq_hit[0] && !led_select[0]) |=> cur.status[0];
	endproperty
	a_hit_sets: assert property (p_hit_sets) else $error("status not set");
	// bus writes land one cycle later, masked to the defined fields
	property p_cfg_write;
		@(posedge clk_i) disable iff (reset_i)
			(wr_i && addr_i == `GPL_OFF_PIN_CONFIG) |=> cur.cfg == ($past(wdata_i) & `GPL_CFG_WMASK);
	endproperty
	a_cfg_write: assert property (p_cfg_write) else $error("config write not masked");
	property p_enable_write;
		@(posedge clk_i) disable iff (reset_i)
			(wr_i && addr_i == `GPL_OFF_IRQ_ENABLE) |=> cur.enable == $past(wdata_i[2:0]);
	endproperty
	a_enable_write: assert property (p_enable_write) else $error("enable write lost");
	// a status read returns the sticky bits and clears them unless a level is still held
	property p_status_read;
		@(posedge clk_i) disable iff (reset_i)
			(rd_i && addr_i == `GPL_OFF_IRQ_STATUS) |=> rdata_o == {29'h0000_0000, $past(cur.status)};
	endproperty
	a_status_read: assert property (p_status_read) else $error("status read wrong");
	property p_status_clear;
		@(posedge clk_i) disable iff (reset_i)
			(rd_i && addr_i == `GPL_OFF_IRQ_STATUS && !(|(link_p.irq_hit & ~led_select)))
			|=> cur.status == 3'h0;
	endproperty
	a_status_clear: assert property (p_status_clear) else $error("status not cleared by read");
	// the pin level bits of a config read come from the synchronised pins
	property p_level_read;
		@(posedge clk_i) disable iff (reset_i)
			(rd_i && addr_i == `GPL_OFF_PIN_CONFIG) |=> rdata_o[2:0] == $past(link_p.level);
	endproperty
	a_level_read: assert property (p_level_read) else $error("pin level read wrong");
	// a pin lent to the led raises no status of its own
	property p_led_mask;
		@(posedge clk_i) disable iff (reset_i) (led_select[0] && !cur.status[0])
			|=> !cur.status[0];
	endproperty
	a_led_mask: assert property (p_led_mask) else $error("led pin raised status");
	// remaining function codes of the two rom pins, one cycle behind their sources
	property p_rom_mode;
		@(posedge clk_i) disable iff (reset_i) (!reset_i && rom_pin_function == GPL_ROMF_ROM)
			|=> (rom_data_pin_o == $past(rom_data_i) && rom_clock_pin_o == $past(rom_clock_i)
			&& !rom_data_pin_oe_o);
	endproperty
	a_rom_mode: assert property (p_rom_mode) else $error("rom pins not passed through");
	property p_ooa_rxdv;
		@(posedge clk_i) disable iff (reset_i) (rom_pin_function == GPL_ROMF_OOA_RXDV)
			|=> (rom_data_pin_o == $past(out_only_value[0]) && rom_clock_pin_o == $past(rx_dv_i)
			&& rom_data_pin_oe_o);
	endproperty
	a_ooa_rxdv: assert property (p_ooa_rxdv) else $error("first output-only pin wrong");
	property p_txen_oob;
		@(posedge clk_i) disable iff (reset_i) (rom_pin_function == GPL_ROMF_TXEN_OOB)
			|=> (rom_data_pin_o == $past(tx_en_i) && rom_clock_pin_o == $past(out_only_value[1])
			&& rom_data_pin_oe_o);
	endproperty
	a_txen_oob: assert property (p_txen_oob) else $error("second output-only pin wrong");
	property p_clks;
		@(posedge clk_i) disable iff (reset_i) (rom_pin_function == GPL_ROMF_CLKS)
			|=> (rom_data_pin_o == $past(tx_clk_i) && rom_clock_pin_o == $past(rx_clk_i) && rom_data_pin_oe_o);
	endproperty
	a_clks: assert property (p_clks) else $error("debug clocks not routed");
	c_irq: cover property (@(posedge clk_i) disable iff (reset_i) $rose(irq_o));
	c_led: cover property (@(posedge clk_i) disable iff (reset_i) led_select[0] && pin_oe_o[0]);
	c_clks: cover property (@(posedge clk_i) disable iff (reset_i) rom_pin_function == GPL_ROMF_CLKS);
	// open-drain output and a status read that really clears something
	c_open_drain: cover property (@(posedge clk_i) disable iff (reset_i) pin_direction[2] && !pin_drive_type[2]);
	c_status_clear: cover property (@(posedge clk_i) disable iff (reset_i)
		rd_i && addr_i == `GPL_OFF_IRQ_STATUS && cur.status != 3'h0);
endmodule : gpl_pin_config

// [hdl/gpl_pin_filter.sv]
// gpl_pin_filter: synchronises the three pins and flags levels held long enough to interrupt
// assumes pins are asynchronous to clk_i
`timescale 1ns/1ps
`include "gpl_defines.svh"
module gpl_pin_filter import gpl_pkg::*; #(
	parameter int FILT_CYCLES = `GPL_FILT_CYCLES
) (
	input wire logic clk_i,
	input wire logic reset_i,
	input wire logic [2:0] pin_i,
	gpl_if.filt port_p
);
	typedef struct packed {
		logic [2:0] sync1;
		logic [2:0] sync2;
		logic [2:0][3:0] run;
		logic [2:0] hit;
	} gpl_filt_type;
	gpl_filt_type cur, next_cur;
	// count cycles at the active polarity; a level must outlast the minimum time
	always_comb begin
		next_cur = cur;
		next_cur.sync1 = pin_i;
		next_cur.sync2 = cur.sync1;
		for (int i = 0; i < 3; i++) begin
			if (cur.sync2[i] == port_p.polarity[i]) begin
				if (cur.run[i] != 4'hF)
					next_cur.run[i] = cur.run[i] + 4'h1;
			end else begin
				next_cur.run[i] = 4'h0;
			end
			next_cur.hit[i] = (next_cur.run[i] > 4'(FILT_CYCLES));
		end
	end
	always_ff @(posedge clk_i) begin
		if (reset_i)
			cur <= '0;
		else
			cur <= next_cur;
	end
	assign port_p.level = cur.sync2;
	assign port_p.irq_hit = cur.hit;
	// an inactive level restarts the count, so no hit can follow it
	property p_short_ignored;
		@(posedge clk_i) disable iff (reset_i) (cur.sync2[0] != port_p.polarity[0]) |=> !cur.hit[0];
	endproperty
	a_short_ignored: assert property (p_short_ignored) else $error("hit after inactive level");
endmodule : gpl_pin_filter

// [hdl/gpl_pkg.sv]
// gpl_pkg: types of the pin configuration block
// assumes gpl_defines.svh for numbers
package gpl_pkg;
	typedef enum logic [2:0] {
		GPL_ROMF_ROM = 3'h0,
		GPL_ROMF_OO_BOTH = 3'h1,
		GPL_ROMF_RSVD_A = 3'h2,
		GPL_ROMF_OOA_RXDV = 3'h3,
		GPL_ROMF_RSVD_B = 3'h4,
		GPL_ROMF_TXEN_OOB = 3'h5,
		GPL_ROMF_TXEN_RXDV = 3'h6,
		GPL_ROMF_CLKS = 3'h7
	} gpl_romf_type;
	typedef enum logic [1:0] {
		GPL_F_IDLE = 2'b01,
		GPL_F_HELD = 2'b10
	} gpl_filt_state_type;
endpackage : gpl_pkg

// [verif/gpl_board.sv]
// gpl_board: board side of the three general pins, a pull-up plus an external driver
// assumes the pin block's drive value and enable for each pin
`timescale 1ns/1ps
module gpl_board (
	input wire logic [2:0] drv_i,
	input wire logic [2:0] oe_i,
	input wire logic ext_en_i,
	input wire logic [2:0] ext_i,
	output logic [2:0] level_o
);
	// the pull-up wins when nobody drives, so a released open-drain pin reads high
	always_comb begin
		for (int i = 0; i < 3; i++) begin
			level_o[i] = oe_i[i] ? drv_i[i] : (ext_en_i ? ext_i[i] : 1'b1);
		end
	end
endmodule : gpl_board

// [verif/gpl_pin_config_tb.sv]
// gpl_pin_config_tb: register-level tests of the pin block
// assumes gpl_board closes the pin loop; the serial rom engine stays idle throughout
`timescale 1ns/1ps
`include "gpl_defines.svh"
module gpl_pin_config_tb;
	localparam logic [7:0] CFG = `GPL_OFF_PIN_CONFIG, STS = `GPL_OFF_IRQ_STATUS, EN = `GPL_OFF_IRQ_ENABLE;
	// expected rom pin levels per function code, bit n for code n
	localparam logic [7:0] DATA_EXP = 8'b1110_0001, CLK_EXP = 8'b0100_1001;
	logic clk_i = 0, reset_i = 1, wr_i = 0, rd_i = 0, ext_en = 1;
	logic tx_en_i = 1, tx_clk_i = 1, rx_dv_i = 1, rx_clk_i = 0, rom_data_i = 1, rom_clock_i = 1;
	logic [7:0] addr_i = 8'h00;
	logic [31:0] wdata_i = 32'h0000_0000, rdata_o;
	logic irq_o, rdp, rcp, rdo, rdoe, rdpoe;
	logic [2:0] pin_i, pin_o, pin_oe_o, led_i = 3'h0, ext = 3'h0;
	int n_fail = 0, compares = 0, cyc = 0;
	int codes[6] = '{0, 1, 3, 5, 6, 7};
	always #25 clk_i = ~clk_i;
	gpl_pin_config dut (.clk_i(clk_i), .reset_i(reset_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
		.rd_i(rd_i), .rdata_o(rdata_o), .irq_o(irq_o), .pin_i(pin_i), .pin_o(pin_o), .pin_oe_o(pin_oe_o),
		.led_i(led_i), .rom_data_i(rom_data_i), .rom_data_o(rdo), .rom_data_oe_o(rdoe), .rom_clock_i(rom_clock_i),
		.tx_en_i(tx_en_i), .tx_clk_i(tx_clk_i), .rx_dv_i(rx_dv_i), .rx_clk_i(rx_clk_i),
		.rom_data_pin_o(rdp), .rom_data_pin_oe_o(rdpoe), .rom_clock_pin_o(rcp));
	gpl_board board (.drv_i(pin_o), .oe_i(pin_oe_o), .ext_en_i(ext_en), .ext_i(ext), .level_o(pin_i));
	task automatic results;
		$display("compares %0d n_fail %0d", compares, n_fail);
		if (n_fail == 0 && compares > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask : results
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			n_fail++;
			$display("unexpected at %0t: got %h want %h", $time, got, exp);
		end
	endtask : chk
	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		@(posedge clk_i);
		addr_i <= a;
		wdata_i <= v;
		wr_i <= 1'b1;
		@(posedge clk_i);
		wr_i <= 1'b0;
	endtask : wr
	// read data stand only in the cycle after the strobe
	task automatic rd(input logic [7:0] a, input logic [31:0] exp);
		@(posedge clk_i);
		addr_i <= a;
		rd_i <= 1'b1;
		@(posedge clk_i);
		rd_i <= 1'b0;
		#1 chk(rdata_o, exp);
	endtask : rd
	task automatic idle(input int n);
		repeat (n) @(posedge clk_i);
		#1;
	endtask : idle
	// a hang is cut short well above the roughly 135 cycles the tests need
	always @(posedge clk_i) begin
		cyc <= cyc + 1;
		if (cyc == 3000) begin
			n_fail++;
			results();
		end
	end
	initial begin
		repeat (3) @(posedge clk_i);
		reset_i <= 1'b0;
		rd(CFG, 32'h0000_0000);
		rd(EN, 32'h0000_0000);
		rd(8'h40, 32'h0000_0000);
		wr(CFG, 32'h8888_F8E0);
		idle(4);
		rd(CFG, 32'h0000_0000);
		ext_en <= 1'b0;
		wr(CFG, 32'h0007_0705);
		idle(5);
		chk(pin_o, 3'b101);
		chk(pin_oe_o, 3'b111);
		rd(CFG, 32'h0007_0705);
		wr(CFG, 32'h0000_0705);
		idle(5);
		chk(pin_oe_o, 3'b010);
		chk(pin_o, 3'b000);
		rd(CFG, 32'h0000_0705);
		ext_en <= 1'b1;
		ext <= 3'b110;
		wr(CFG, 32'h0000_0000);
		idle(5);
		rd(CFG, 32'h0000_0006);
		// reserved codes are never written and no rom cycle runs meanwhile
		for (int k = 0; k < 6; k++) begin
			wr(CFG, 32'(codes[k] << 20));
			idle(3);
			chk(rdp, DATA_EXP[codes[k]]);
			chk(rcp, CLK_EXP[codes[k]]);
			chk(rdo, DATA_EXP[codes[k]]);
			chk(rdpoe, codes[k] != 0);
			chk(rdoe, 1'b0);
		end
		wr(CFG, 32'h0010_0018);
		idle(3);
		chk({rcp, rdp}, 2'b11);
		wr(CFG, 32'h0100_0000);
		idle(8);
		rd(STS, 32'h0000_0007);
		rd(STS, 32'h0000_0000);
		wr(EN, 32'h0000_0007);
		idle(2);
		chk(irq_o, 1'b0);
		ext <= 3'b111;
		idle(8);
		chk(irq_o, 1'b1);
		wr(EN, 32'h0000_0006);
		idle(2);
		chk(irq_o, 1'b0);
		ext <= 3'b110;
		idle(8);
		rd(STS, 32'h0000_0001);
		rd(STS, 32'h0000_0000);
		led_i <= 3'b001;
		wr(CFG, 32'h1100_0000);
		ext <= 3'b111;
		wr(EN, 32'h0000_0001);
		idle(8);
		chk(irq_o, 1'b0);
		rd(STS, 32'h0000_0000);
		results();
	end
endmodule : gpl_pin_config_tb
